// *** include/gauge_defs.svh ***
// Widths, codes and reset values of the gauge serial input port
`ifndef GAUGE_DEFS_SVH
`define GAUGE_DEFS_SVH

// ==========================================================
// Serial word layout
`define WORD_W        12
`define ADDR_W        2
`define PAYLOAD_W     10
`define MAJ_OCT_W     3
`define MAJ_STEP_W    7
`define MIN_PAD_W     2
`define MIN_CODE_W    8

// ==========================================================
// Gauge addresses and gauge indices
`define GAUGE_N       3
`define ADDR_MAJOR    2'h0
`define ADDR_MINOR1   2'h1
`define ADDR_MINOR2   2'h2
`define ADDR_ALL_OFF  2'h3
`define IDX_MAJOR     0
`define IDX_MINOR1    1
`define IDX_MINOR2    2
`define MIN_PAD_OK    2'h0

// ==========================================================
// Reset values
`define WORD_RST      12'h000
`define CODES_RST     26'h0000000
`define FAULT_RST     4'h0
`define SEL_NONE      3'h0
`define BIT_RST       1'b0
`define BIT_SET       1'b1

`endif

// *** include/gauge_pkg.sv ***
// Types shared by the gauge serial input port
`include "gauge_defs.svh"

package gauge_pkg;

    // ==========================================================
    // Serial word and its two payload views
    typedef struct packed {
        logic [`ADDR_W-1:0]     addr;
        logic [`PAYLOAD_W-1:0]  payload;
    } gauge_word_t;

    typedef struct packed {
        logic [`MAJ_OCT_W-1:0]  octant;
        logic [`MAJ_STEP_W-1:0] step;
    } major_view_t;

    typedef struct packed {
        logic [`MIN_PAD_W-1:0]  pad;
        logic [`MIN_CODE_W-1:0] code;
    } minor_view_t;

    // ==========================================================
    // Stored codes handed to the converter and multiplexer stage
    typedef struct packed {
        major_view_t            major;
        logic [`MIN_CODE_W-1:0] minor1;
        logic [`MIN_CODE_W-1:0] minor2;
    } gauge_codes_t;

    // ==========================================================
    // Fault reports from the output buffers
    typedef struct packed {
        logic [`GAUGE_N-1:0]    shorted;
        logic                   thermal;
    } fault_in_t;

    // ==========================================================
    // Output driver state
    typedef enum logic [1:0] {
        DRV_IDLE,
        DRV_ON,
        DRV_FAULT_OFF,
        DRV_ADDR_OFF
    } drive_state_t;

endpackage

// *** rtl/gauge_link_shifter.sv ***
// Serial-clock side shift register and serial data output
`timescale 1ns/100ps
`include "gauge_defs.svh"

module gauge_link_shifter (
    input  wire logic                    sclk,
    input  wire logic                    reset,
    input  wire logic                    cs,
    input  wire logic                    si,
    output gauge_pkg::gauge_word_t       word_q,
    output logic                         so_q
);

    gauge_pkg::gauge_word_t word_d;
    logic                   so_d;

    // ==========================================================
    // Shift path
    always_comb begin
        word_d = word_q;
        if (cs) begin
            word_d = gauge_pkg::gauge_word_t'(
                {word_q[`WORD_W-2:0], si});
        end
        // Oldest bit leaves first so a chained device gets the old word
        so_d = word_q[`WORD_W-1];
    end

    // Serial clock may stand still, so reset clears without it
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            word_q <= gauge_pkg::gauge_word_t'(`WORD_RST);
        end else begin
            word_q <= word_d;
        end
    end

    always_ff @(negedge sclk or posedge reset) begin
        if (reset) begin
            so_q <= `BIT_RST;
        end else begin
            so_q <= so_d;
        end
    end

endmodule

// *** rtl/gauge_serial_input_port.sv ***
// Serial input port of a three-gauge coil driver, system clock side
`timescale 1ns/100ps
`include "gauge_defs.svh"

module gauge_serial_input_port (
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic                    sclk,
    input  wire logic                    cs,
    input  wire logic                    si,
    input  gauge_pkg::fault_in_t         fault_in,
    output logic                         so,
    output gauge_pkg::gauge_codes_t      codes_q,
    output logic [`GAUGE_N-1:0]          gauge_update_q,
    output logic                         drivers_on_q,
    output logic                         fault_n_q,
    output logic                         pad_err_q
);

    // ==========================================================
    // Declarations
    gauge_pkg::gauge_word_t  link_word;
    logic                    link_so;

    logic                    cs_s1_q;
    logic                    cs_s2_q;
    logic                    cs_prev_q;
    logic                    cs_s1_d;
    logic                    cs_s2_d;
    logic                    cs_prev_d;
    logic                    cs_fall;

    gauge_pkg::fault_in_t    fault_s1_q;
    gauge_pkg::fault_in_t    fault_s2_q;
    gauge_pkg::fault_in_t    fault_s1_d;
    gauge_pkg::fault_in_t    fault_s2_d;
    logic                    fault_any;

    gauge_pkg::gauge_word_t  held_q;
    gauge_pkg::gauge_word_t  held_d;
    logic                    take_q;
    logic                    take_d;

    gauge_pkg::gauge_codes_t codes_d;
    logic [`GAUGE_N-1:0]     gauge_update_d;
    logic                    pad_err_d;

    gauge_pkg::drive_state_t drv_q;
    gauge_pkg::drive_state_t drv_d;
    logic                    drivers_on_d;
    logic                    fault_n_d;

    // ==========================================================
    // Functions
    // One-hot gauge select; the all-off address selects nothing
    function automatic logic [`GAUGE_N-1:0] gauge_select(
        input gauge_pkg::gauge_word_t w
    );
        logic [`GAUGE_N-1:0] sel;
        sel = `SEL_NONE;
        sel[`IDX_MAJOR]  = (w.addr == `ADDR_MAJOR);
        sel[`IDX_MINOR1] = (w.addr == `ADDR_MINOR1);
        sel[`IDX_MINOR2] = (w.addr == `ADDR_MINOR2);
        return sel;
    endfunction

    function automatic logic all_off_word(
        input gauge_pkg::gauge_word_t w
    );
        return (w.addr == `ADDR_ALL_OFF);
    endfunction

    // ==========================================================
    // Link side
    // The shifter runs on the serial clock; its word only changes
    // while select is high, so it is stable once select has fallen.
    gauge_link_shifter u_shifter (
        .sclk   (sclk),
        .reset  (reset),
        .cs     (cs),
        .si     (si),
        .word_q (link_word),
        .so_q   (link_so)
    );

    // Serial output is a flop of the link side
    assign so = link_so;

    // ==========================================================
    // Chip select synchroniser and falling edge
    always_comb begin
        cs_s1_d   = cs;
        cs_s2_d   = cs_s1_q;
        cs_prev_d = cs_s2_q;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cs_s1_q   <= `BIT_RST;
            cs_s2_q   <= `BIT_RST;
            cs_prev_q <= `BIT_RST;
        end else begin
            cs_s1_q   <= cs_s1_d;
            cs_s2_q   <= cs_s2_d;
            cs_prev_q <= cs_prev_d;
        end
    end

    assign cs_fall = cs_prev_q & ~cs_s2_q;

    // ==========================================================
    // Fault report synchroniser
    always_comb begin
        fault_s1_d = fault_in;
        fault_s2_d = fault_s1_q;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fault_s1_q <= gauge_pkg::fault_in_t'(`FAULT_RST);
            fault_s2_q <= gauge_pkg::fault_in_t'(`FAULT_RST);
        end else begin
            fault_s1_q <= fault_s1_d;
            fault_s2_q <= fault_s2_d;
        end
    end

    assign fault_any = (|fault_s2_q.shorted) | fault_s2_q.thermal;

    // ==========================================================
    // Word hand-over from the link side
    // Sampled on the third system clock edge after select falls; the word has
    // been still since the last serial rising edge before that.
    always_comb begin
        held_d = held_q;
        take_d = cs_fall;
        if (cs_fall) begin
            held_d = link_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            held_q <= gauge_pkg::gauge_word_t'(`WORD_RST);
            take_q <= `BIT_RST;
        end else begin
            held_q <= held_d;
            take_q <= take_d;
        end
    end

    // ==========================================================
    // Stored gauge codes
    always_comb begin
        gauge_pkg::major_view_t maj;
        gauge_pkg::minor_view_t mnr;
        logic [`GAUGE_N-1:0]    sel;
        maj            = gauge_pkg::major_view_t'(held_q.payload);
        mnr            = gauge_pkg::minor_view_t'(held_q.payload);
        sel            = gauge_select(held_q);
        codes_d        = codes_q;
        gauge_update_d = `SEL_NONE;
        pad_err_d      = pad_err_q;
        if (take_q) begin
            // Only the addressed gauge changes
            gauge_update_d = sel;
            if (sel[`IDX_MAJOR]) begin
                codes_d.major = maj;
            end
            if (sel[`IDX_MINOR1]) begin
                codes_d.minor1 = mnr.code;
            end
            if (sel[`IDX_MINOR2]) begin
                codes_d.minor2 = mnr.code;
            end
            // Pad bits are ignored but a nonzero pad is reported
            pad_err_d = (sel[`IDX_MINOR1] | sel[`IDX_MINOR2])
                        & (mnr.pad != `MIN_PAD_OK);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            codes_q        <= gauge_pkg::gauge_codes_t'(`CODES_RST);
            gauge_update_q <= `SEL_NONE;
            pad_err_q      <= `BIT_RST;
        end else begin
            codes_q        <= codes_d;
            gauge_update_q <= gauge_update_d;
            pad_err_q      <= pad_err_d;
        end
    end

    // ==========================================================
    // Output driver control
    // A fault present at the latch wins over the re-enable, so a
    // short that persists never lets the drivers back on.
    always_comb begin
        drv_d = drv_q;
        unique case (drv_q)
            gauge_pkg::DRV_IDLE: begin
                if (take_q) begin
                    if (all_off_word(held_q)) begin
                        drv_d = gauge_pkg::DRV_ADDR_OFF;
                    end else if (fault_any) begin
                        drv_d = gauge_pkg::DRV_FAULT_OFF;
                    end else begin
                        drv_d = gauge_pkg::DRV_ON;
                    end
                end
            end
            gauge_pkg::DRV_ON: begin
                if (take_q && all_off_word(held_q)) begin
                    drv_d = gauge_pkg::DRV_ADDR_OFF;
                end else if (fault_any) begin
                    drv_d = gauge_pkg::DRV_FAULT_OFF;
                end
            end
            gauge_pkg::DRV_FAULT_OFF: begin
                if (take_q) begin
                    if (all_off_word(held_q)) begin
                        drv_d = gauge_pkg::DRV_ADDR_OFF;
                    end else if (!fault_any) begin
                        drv_d = gauge_pkg::DRV_ON;
                    end
                end
            end
            gauge_pkg::DRV_ADDR_OFF: begin
                if (take_q && !all_off_word(held_q)) begin
                    if (fault_any) begin
                        drv_d = gauge_pkg::DRV_FAULT_OFF;
                    end else begin
                        drv_d = gauge_pkg::DRV_ON;
                    end
                end
            end
        endcase
        drivers_on_d = (drv_d == gauge_pkg::DRV_ON);
        // Health is shown as it is now, not as latched
        fault_n_d    = ~fault_any;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drv_q        <= gauge_pkg::DRV_IDLE;
            drivers_on_q <= `BIT_RST;
            fault_n_q    <= `BIT_SET;
        end else begin
            drv_q        <= drv_d;
            drivers_on_q <= drivers_on_d;
            fault_n_q    <= fault_n_d;
        end
    end

endmodule

// *** tb/gauge_port_sva.sv ***
// Port assertions for the gauge serial input port
`timescale 1ns/100ps
`include "gauge_defs.svh"

module gauge_port_sva (
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic                    sclk,
    input  wire logic                    cs,
    input  wire logic                    si,
    input  gauge_pkg::fault_in_t         fault_in,
    input  wire logic                    so,
    input  gauge_pkg::gauge_codes_t      codes_q,
    input  wire logic [`GAUGE_N-1:0]     gauge_update_q,
    input  wire logic                    drivers_on_q,
    input  wire logic                    fault_n_q,
    input  wire logic                    pad_err_q
);
    // ==========================================================
    // Shadow of the link shift register
    logic [`WORD_W-1:0] shadow_q;
    logic [`WORD_W-1:0] shadow_d;

    always_comb begin
        shadow_d = cs ? {shadow_q[`WORD_W-2:0], si} : shadow_q;
    end

    // Async clear mirrors the link side, whose clock may be stopped
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            shadow_q <= `WORD_RST;
        end else begin
            shadow_q <= shadow_d;
        end
    end

    // ==========================================================
    // Assertions
    so_order_a: assert property (@(posedge sclk) disable iff (reset)
        so == shadow_q[`WORD_W-1]) else $error("serial out order");
    upd_onehot_a: assert property (@(posedge clk_sys) disable iff (reset)
        $onehot0(gauge_update_q)) else $error("update not onehot");
    upd_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
        |gauge_update_q |=> gauge_update_q == '0) else $error("long pulse");
    major_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
        !gauge_update_q[0] |-> $stable(codes_q.major)) else $error("major");
    minor1_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
        !gauge_update_q[1] |-> $stable(codes_q.minor1)) else $error("minor1");
    minor2_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
        !gauge_update_q[2] |-> $stable(codes_q.minor2)) else $error("minor2");
    fault_low_a: assert property (@(posedge clk_sys) disable iff (reset)
        (|fault_in)[*6] |-> !fault_n_q) else $error("fault not shown");
    fault_high_a: assert property (@(posedge clk_sys) disable iff (reset)
        (fault_in == '0)[*6] |-> fault_n_q) else $error("false fault");
    drv_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        (|fault_in)[*6] |-> !drivers_on_q) else $error("drivers on in fault");
    drv_on_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(drivers_on_q) |-> |gauge_update_q) else $error("drivers on");
endmodule

bind gauge_serial_input_port gauge_port_sva chk (.clk_sys, .reset, .sclk,
    .cs, .si, .fault_in, .so, .codes_q, .gauge_update_q, .drivers_on_q,
    .fault_n_q, .pad_err_q);

// *** tb/mcu_model.sv ***
// Serial bus master model that shifts gauge words into the port
`timescale 1ns/100ps
`include "gauge_defs.svh"

module mcu_model (
    output logic                         sclk,
    output logic                         cs,
    output logic                         si,
    input  wire logic                    so
);
    localparam int HALF = 24;

    initial begin
        sclk = 1'b0;
        cs = 1'b0;
        si = 1'b1;
    end

    // ==========================================================
    // One frame, MSB first; returns what the port shifted out
    task automatic xfer(input logic [`WORD_W-1:0] w,
                        output logic [`WORD_W-1:0] r);
        r = '0;
        cs = 1'b1;
        for (int i = `WORD_W-1; i >= 0; i--) begin
            si = w[i];
            #HALF sclk = 1'b1;
            r = {r[`WORD_W-2:0], so};
            #HALF sclk = 1'b0;
        end
        // Released data line must not keep showing the last bit
        si = ~si;
        #HALF cs = 1'b0;
        #60;
    endtask

    // Clock pulses with select low; the port must ignore them
    task automatic stray(input int n);
        repeat (n) begin
            si = 1'($urandom);
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        si = ~si;
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the gauge serial input port
`timescale 1ns/100ps
`include "gauge_defs.svh"

module testbench;
    logic                    clk_sys;
    logic                    reset;
    logic                    sclk;
    logic                    cs;
    logic                    si;
    logic                    so;
    gauge_pkg::fault_in_t    fault_in;
    gauge_pkg::gauge_codes_t codes_q;
    gauge_pkg::gauge_codes_t model;
    logic [`GAUGE_N-1:0]     gauge_update_q;
    logic                    drivers_on_q;
    logic                    fault_n_q;
    logic                    pad_err_q;
    logic [`WORD_W-1:0]      prev;
    logic [`WORD_W-1:0]      back;
    logic [31:0]             notes[$];
    int                      err_count;
    int                      total_checks;

    gauge_serial_input_port dut (.clk_sys, .reset, .sclk, .cs, .si,
        .fault_in, .so, .codes_q, .gauge_update_q, .drivers_on_q,
        .fault_n_q, .pad_err_q);
    mcu_model mcu (.sclk, .cs, .si, .so);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Comparison and verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Each update pulse consumes the oldest expected note
    always @(posedge clk_sys) begin
        if (reset === 1'b0 && gauge_update_q !== '0) begin
            check({gauge_update_q, codes_q},
                  notes.size() ? notes.pop_front() : 32'h0);
        end
    end

    task automatic send(input logic [`WORD_W-1:0] w);
        gauge_pkg::gauge_word_t gw;
        gw = w;
        case (gw.addr)
            `ADDR_MAJOR:  model.major = gw.payload;
            `ADDR_MINOR1: model.minor1 = gw.payload[7:0];
            `ADDR_MINOR2: model.minor2 = gw.payload[7:0];
            default: ;
        endcase
        if (gw.addr != `ADDR_ALL_OFF) begin
            notes.push_back({3'(1 << gw.addr), model});
        end
        mcu.xfer(w, back);
        check(32'(back), 32'(prev));
        prev = w;
        repeat (10) @(posedge clk_sys);
        check(32'(drivers_on_q), 32'(gw.addr != `ADDR_ALL_OFF));
        if (gw.addr == `ADDR_MINOR1 || gw.addr == `ADDR_MINOR2) begin
            check(32'(pad_err_q), 32'(gw.payload[9:8] != 0));
        end
    endtask

    task automatic start();
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        model = '0;
        prev = '0;
        @(posedge clk_sys);
        #1;
        check({codes_q, gauge_update_q, drivers_on_q, fault_n_q, pad_err_q},
              32'h2);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [`WORD_W-1:0] w;
        err_count = 0;
        total_checks = 0;
        reset = 1'b1;
        fault_in = '0;
        void'($urandom(32'h4551));
        start();
        for (int i = 0; i < 12; i++) begin
            w = 12'($urandom);
            w[11:10] = 2'(i % 3);
            if (i % 3 != 0) w[9:8] = `MIN_PAD_OK;
            send(w);
        end
        send({`ADDR_MINOR1, 2'h3, 8'($urandom)});
        send({`ADDR_ALL_OFF, 10'($urandom)});
        mcu.stray(5);
        send({`ADDR_MINOR2, `MIN_PAD_OK, 8'($urandom)});
        for (int b = 0; b < 4; b++) begin
            @(posedge clk_sys) fault_in <= 4'(1 << b);
            repeat (10) @(posedge clk_sys);
            check({fault_n_q, drivers_on_q}, 32'h0);
            @(posedge clk_sys) fault_in <= '0;
            repeat (10) @(posedge clk_sys);
            check({fault_n_q, drivers_on_q}, 32'h2);
            send({`ADDR_MAJOR, 10'($urandom)});
        end
        @(posedge clk_sys) reset <= 1'b1;
        start();
        send({`ADDR_MAJOR, 10'($urandom)});
        report_and_stop();
    end

    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule
